// ### shared/rss_pkg.sv
// shared constants for the rail strobe slot select register
package rss_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] SLOT_REG_ADDR  = 8'h25;
    localparam logic [7:0] SLOT_REG_RESET = 8'h73;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int         FIELD_WIDTH    = 4;
    localparam int         SWITCH_LSB     = 4;
    localparam int         REGULATOR_LSB  = 0;
    localparam int         RAIL_COUNT     = 2;
    localparam int         RAIL_SWITCH    = 1;
    localparam int         RAIL_REGULATOR = 0;

    // ------------------------------------------------------------
    // slot codes
    // ------------------------------------------------------------
    localparam logic [3:0] SLOT_FIRST     = 4'h3;
    localparam logic [3:0] SLOT_LAST      = 4'hA;

    // ------------------------------------------------------------
    // write protection states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LOCK_CLOSED = 2'h1,
        LOCK_ARMED  = 2'h2
    } rss_lock_type;

endpackage : rss_pkg

// ### shared/rss_slot_if.sv
// interface between the slot register and one rail's slot decoder
`timescale 1ns/1ps
interface rss_slot_if;
    logic [3:0] slot;
    logic       strobe_valid;
    logic [3:0] strobe_num;
    logic       managed;
    logic       hit;

    modport reg_side (
        output slot,
        output strobe_valid,
        output strobe_num,
        input  managed,
        input  hit
    );

    modport dec_side (
        input  slot,
        input  strobe_valid,
        input  strobe_num,
        output managed,
        output hit
    );
endinterface : rss_slot_if

// ### rtl/rss_slot_decode.sv
// decodes one 4-bit strobe slot field against the running strobe
`timescale 1ns/1ps
module rss_slot_decode (
    rss_slot_if.dec_side port
);

    // ------------------------------------------------------------
    // slot decode
    // ------------------------------------------------------------
    // codes below the first slot and above the last leave the rail alone
    always_comb
    begin
        port.managed = (port.slot >= rss_pkg::SLOT_FIRST) &&
                       (port.slot <= rss_pkg::SLOT_LAST); // RULE2 RULE4
        port.hit     = port.managed && port.strobe_valid &&
                       (port.strobe_num == port.slot); // RULE3
    end

endmodule : rss_slot_decode

// ### rtl/rss_top.sv
// sequencer slot register for the load switch and the linear regulator
//
// Operation
// RULE1: 8-bit slot register at 0x25, reset 0x73
// RULE2: codes 0h to 2h leave rail unsequenced
// RULE3: codes 3h to Ah enable rail at strobe
// RULE4: codes Bh to Fh leave rail unsequenced
// RULE5: load switch slot resets to 7h
// RULE6: regulator slot resets to 3h
// RULE7: writes accepted only after fresh password unlock
`timescale 1ns/1ps
module rss_top #(
    parameter int ADDR_WIDTH = 8
) (
    input  wire logic                  clock_i,
    input  wire logic                  rst_i,
    input  wire logic                  wr_en_i,
    input  wire logic                  rd_en_i,
    input  wire logic [ADDR_WIDTH-1:0] sub_addr_i,
    input  wire logic [7:0]            wr_data_i,
    input  wire logic                  unlock_i,
    input  wire logic                  strobe_valid_i,
    input  wire logic [3:0]            strobe_num_i,
    input  wire logic                  seq_clear_i,
    output logic [7:0]                 rd_data_o,
    output logic                       rd_valid_o,
    output logic                       wr_refused_o,
    output logic                       write_armed_o,
    output logic [3:0]                 load_switch_slot_o,
    output logic [3:0]                 regulator_slot_o,
    output logic                       switch_managed_o,
    output logic                       regulator_managed_o,
    output logic                       load_switch_en_o,
    output logic                       regulator_en_o
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (ADDR_WIDTH < 7)
    begin : g_bad_addr
        $error("rss_top: ADDR_WIDTH too narrow for the subaddress");
    end

    localparam logic [ADDR_WIDTH-1:0] MY_ADDR =
        ADDR_WIDTH'(rss_pkg::SLOT_REG_ADDR);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]             switch_and_regulator_slot;
    logic [7:0]             next_slot_reg;
    rss_pkg::rss_lock_type  lock_state;
    rss_pkg::rss_lock_type  next_lock_state;
    logic [7:0]             next_rd_data;
    logic                   next_rd_valid;
    logic                   next_wr_refused;
    logic [1:0]             rail_en;
    logic [1:0]             next_rail_en;
    logic [1:0]             rail_managed;
    logic [1:0]             rail_hit;
    logic                   addr_hit;

    assign addr_hit = (sub_addr_i == MY_ADDR);

    // ------------------------------------------------------------
    // per-rail slot decoders
    // ------------------------------------------------------------
    for (genvar r = 0; r < rss_pkg::RAIL_COUNT; r++)
    begin : g_rail
        localparam int LSB = (r == rss_pkg::RAIL_SWITCH) ?
                             rss_pkg::SWITCH_LSB : rss_pkg::REGULATOR_LSB;
        rss_slot_if slot_if ();

        assign slot_if.slot =
            switch_and_regulator_slot[LSB +: rss_pkg::FIELD_WIDTH];
        assign slot_if.strobe_valid = strobe_valid_i;
        assign slot_if.strobe_num   = strobe_num_i;
        assign rail_managed[r]      = slot_if.managed;
        assign rail_hit[r]          = slot_if.hit;

        rss_slot_decode u_dec (
            .port (slot_if.dec_side)
        );
    end

    // ------------------------------------------------------------
    // register and write protection
    // ------------------------------------------------------------
    // one unlock buys exactly one write to this register, so a stray
    // later write cannot silently move a rail in the power-up order
    always_comb
    begin
        next_slot_reg   = switch_and_regulator_slot;
        next_lock_state = lock_state;
        next_wr_refused = 1'b0;
        case (lock_state)
            rss_pkg::LOCK_CLOSED:
            begin
                if (wr_en_i && addr_hit)
                begin
                    next_wr_refused = 1'b1; // RULE7
                end
                if (unlock_i)
                begin
                    next_lock_state = rss_pkg::LOCK_ARMED; // RULE7
                end
            end
            rss_pkg::LOCK_ARMED:
            begin
                if (wr_en_i && addr_hit)
                begin
                    next_slot_reg   = wr_data_i; // RULE1
                    next_lock_state = rss_pkg::LOCK_CLOSED; // RULE7
                end
            end
            default:
            begin
                next_lock_state = rss_pkg::LOCK_CLOSED;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            // reset value places the switch at slot 7, regulator at 3
            switch_and_regulator_slot <= rss_pkg::SLOT_REG_RESET; // RULE5 RULE6
            lock_state                <= rss_pkg::LOCK_CLOSED;
            wr_refused_o              <= 1'b0;
        end
        else
        begin
            switch_and_regulator_slot <= next_slot_reg;
            lock_state                <= next_lock_state;
            wr_refused_o              <= next_wr_refused;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // other subaddresses belong to neighbouring registers: no answer here
    always_comb
    begin
        next_rd_valid = rd_en_i && addr_hit;
        next_rd_data  = next_rd_valid ? switch_and_regulator_slot : 8'h00;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            rd_data_o  <= next_rd_data;
            rd_valid_o <= next_rd_valid;
        end
    end

    // ------------------------------------------------------------
    // rail enables
    // ------------------------------------------------------------
    // an enable set by a strobe holds until the sequence is cleared;
    // a strobe in the clearing cycle still wins
    always_comb
    begin
        next_rail_en = rail_en;
        if (seq_clear_i)
        begin
            next_rail_en = 2'h0;
        end
        next_rail_en = next_rail_en | rail_hit; // RULE3
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rail_en <= 2'h0;
        end
        else
        begin
            rail_en <= next_rail_en;
        end
    end

    // ------------------------------------------------------------
    // registered status outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            write_armed_o       <= 1'b0;
            load_switch_slot_o  <= rss_pkg::SLOT_REG_RESET[
                rss_pkg::SWITCH_LSB +: rss_pkg::FIELD_WIDTH];
            regulator_slot_o    <= rss_pkg::SLOT_REG_RESET[
                rss_pkg::REGULATOR_LSB +: rss_pkg::FIELD_WIDTH];
            switch_managed_o    <= 1'b1;
            regulator_managed_o <= 1'b1;
            load_switch_en_o    <= 1'b0;
            regulator_en_o      <= 1'b0;
        end
        else
        begin
            write_armed_o       <= (next_lock_state == rss_pkg::LOCK_ARMED);
            load_switch_slot_o  <= next_slot_reg[
                rss_pkg::SWITCH_LSB +: rss_pkg::FIELD_WIDTH];
            regulator_slot_o    <= next_slot_reg[
                rss_pkg::REGULATOR_LSB +: rss_pkg::FIELD_WIDTH];
            switch_managed_o    <= rail_managed[rss_pkg::RAIL_SWITCH];
            regulator_managed_o <= rail_managed[rss_pkg::RAIL_REGULATOR];
            load_switch_en_o    <= next_rail_en[rss_pkg::RAIL_SWITCH];
            regulator_en_o      <= next_rail_en[rss_pkg::RAIL_REGULATOR];
        end
    end

endmodule : rss_top

// ### tb/rss_top_props.sv
// concurrent checks on the slot register ports
`timescale 1ns/1ps
module rss_top_props #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic                  clock_i,
    input wire logic                  rst_i,
    input wire logic                  wr_en_i,
    input wire logic                  rd_en_i,
    input wire logic [ADDR_WIDTH-1:0] sub_addr_i,
    input wire logic [7:0]            wr_data_i,
    input wire logic                  unlock_i,
    input wire logic                  strobe_valid_i,
    input wire logic [3:0]            strobe_num_i,
    input wire logic                  seq_clear_i,
    input wire logic [7:0]            rd_data_o,
    input wire logic                  rd_valid_o,
    input wire logic                  wr_refused_o,
    input wire logic                  write_armed_o,
    input wire logic [3:0]            load_switch_slot_o,
    input wire logic [3:0]            regulator_slot_o,
    input wire logic                  switch_managed_o,
    input wire logic                  load_switch_en_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic sel;
    logic ls_hit;
    assign sel = sub_addr_i == rss_pkg::SLOT_REG_ADDR;
    assign ls_hit = strobe_valid_i && strobe_num_i == load_switch_slot_o
        && load_switch_slot_o inside {[4'h3:4'hA]};
    sequence s_armed_wr;
        wr_en_i && sel && write_armed_o && !unlock_i;
    endsequence
    sequence s_idle_off;
        !load_switch_en_o && !ls_hit;
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_read_answer: assert property (rd_en_i && sel |=> rd_valid_o
        && rd_data_o == $past({load_switch_slot_o, regulator_slot_o}))
        else $error("read answer wrong");
    a_other_silent: assert property (rd_en_i && !sel |=> !rd_valid_o)
        else $error("answer to foreign address");
    a_locked_refuse: assert property (wr_en_i && sel && !write_armed_o
        |=> wr_refused_o && $stable(load_switch_slot_o))
        else $error("locked write not refused");
    a_write_take: assert property (s_armed_wr |=> !write_armed_o
        && {load_switch_slot_o, regulator_slot_o} == $past(wr_data_i))
        else $error("armed write not taken");
    a_managed_lag: assert property (1'b1 |=> switch_managed_o
        == $past(load_switch_slot_o inside {[4'h3:4'hA]}))
        else $error("managed flag wrong");
    a_strobe_sets: assert property (ls_hit |=> load_switch_en_o)
        else $error("matching strobe missed");
    a_enable_cause: assert property (s_idle_off |=> !load_switch_en_o)
        else $error("enable without matching strobe");
    a_clear_drop: assert property (seq_clear_i && !ls_hit |=> !load_switch_en_o)
        else $error("enable survived clear");
endmodule : rss_top_props

bind rss_top rss_top_props #(.ADDR_WIDTH(ADDR_WIDTH)) rss_top_props_i (.*);

// ### tb/rss_top_tb_top.sv
// self-checking bench for the slot register
`timescale 1ns/1ps
module rss_top_tb_top;
    logic       clock_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       wr_en_i = 1'b0;
    logic       rd_en_i = 1'b0;
    logic       unlock_i = 1'b0;
    logic       strobe_valid_i = 1'b0;
    logic       seq_clear_i = 1'b0;
    logic [7:0] sub_addr_i = 8'h00;
    logic [7:0] wr_data_i = 8'h00;
    logic [3:0] strobe_num_i = 4'h0;
    logic [7:0] rd_data_o;
    logic       rd_valid_o, wr_refused_o, write_armed_o;
    logic [3:0] load_switch_slot_o, regulator_slot_o;
    logic       switch_managed_o, regulator_managed_o;
    logic       load_switch_en_o, regulator_en_o;
    int         num_errors = 0;
    int         n_tests = 0;
    always #5 clock_i = ~clock_i;
    rss_top rss_top_i (.*);
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step();
        @(negedge clock_i);
    endtask : step
    task automatic write(input logic [7:0] addr, data);
        wr_en_i = 1'b1;
        sub_addr_i = addr;
        wr_data_i = data;
        step();
        wr_en_i = 1'b0;
    endtask : write
    task automatic unlock();
        unlock_i = 1'b1;
        step();
        unlock_i = 1'b0;
    endtask : unlock
    task automatic read(input logic [7:0] addr, input logic v, logic [7:0] e);
        rd_en_i = 1'b1;
        sub_addr_i = addr;
        step();
        rd_en_i = 1'b0;
        check("rd_valid", rd_valid_o, v);
        check("rd_data", rd_data_o, e);
    endtask : read
    function automatic logic on_at(input logic [3:0] c, n);
        return c >= 4'h3 && c <= 4'hA && n >= c;
    endfunction : on_at
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("ls_slot", load_switch_slot_o, 8'h07);
        check("rg_slot", regulator_slot_o, 8'h03);
        read(8'h25, 1'b1, 8'h73);
        read(8'h24, 1'b0, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_lock();
        write(8'h25, 8'h55);
        check("refused", wr_refused_o, 1'b1);
        read(8'h25, 1'b1, 8'h73);
        unlock();
        write(8'h24, 8'h11);
        check("armed", write_armed_o, 1'b1);
        write(8'h25, 8'h5A);
        check("slots", {load_switch_slot_o, regulator_slot_o}, 8'h5A);
        check("disarmed", write_armed_o, 1'b0);
        write(8'h25, 8'h66);
        check("relock", wr_refused_o, 1'b1);
        read(8'h25, 1'b1, 8'h5A);
        check("refuse_pulse", wr_refused_o, 1'b0);
        $display("test lock done");
    endtask : t_lock
    task automatic t_codes();
        logic [3:0] c;
        for (int k = 0; k < 16; k++)
        begin
            c = 4'(k);
            unlock();
            write(8'h25, {c, ~c});
            seq_clear_i = 1'b1;
            step();
            seq_clear_i = 1'b0;
            check("ls_man", switch_managed_o, on_at(c, 4'hF));
            check("rg_man", regulator_managed_o, on_at(~c, 4'hF));
            check("ls_clr", load_switch_en_o, 1'b0);
            strobe_valid_i = 1'b1;
            for (int n = 0; n < 16; n++)
            begin
                strobe_num_i = 4'(n);
                step();
                check("ls_en", load_switch_en_o, on_at(c, 4'(n)));
                check("rg_en", regulator_en_o, on_at(~c, 4'(n)));
            end
            strobe_valid_i = 1'b0;
        end
        $display("test codes done");
    endtask : t_codes
    // a strobe in the clearing cycle must still set its rail
    task automatic t_clear();
        unlock();
        write(8'h25, 8'h73);
        strobe_num_i = 4'h3;
        step();
        check("rg_novalid", regulator_en_o, 1'b0);
        seq_clear_i = 1'b1;
        strobe_valid_i = 1'b1;
        step();
        seq_clear_i = 1'b0;
        strobe_valid_i = 1'b0;
        check("rg_set_wins", regulator_en_o, 1'b1);
        check("ls_no_match", load_switch_en_o, 1'b0);
        strobe_num_i = 4'h7;
        strobe_valid_i = 1'b1;
        step();
        strobe_valid_i = 1'b0;
        check("ls_at_7", load_switch_en_o, 1'b1);
        check("rg_held", regulator_en_o, 1'b1);
        seq_clear_i = 1'b1;
        step();
        seq_clear_i = 1'b0;
        check("ls_cleared", load_switch_en_o, 1'b0);
        check("rg_cleared", regulator_en_o, 1'b0);
        $display("test clear done");
    endtask : t_clear
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (20000) @(posedge clock_i);
        num_errors++;
        final_report();
    end
    initial
    begin
        step();
        step();
        rst_i = 1'b0;
        t_reset();
        t_lock();
        t_codes();
        t_clear();
        final_report();
    end
endmodule : rss_top_tb_top
